// File: light_alarm_pkg.sv
// Package with register map, field layout and timing constants for the block.
package light_alarm_pkg;

   // -------------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------------
   localparam logic [7:0] OFS_SEL_PRI    = 8'h00;
   localparam logic [7:0] OFS_SEL_SEC    = 8'h04;
   localparam logic [7:0] OFS_BOOST      = 8'h08;
   localparam logic [7:0] OFS_DURATION   = 8'h0c;
   localparam logic [7:0] OFS_CONTROL    = 8'h10;
   localparam logic [7:0] OFS_FACTORS_P  = 8'h14;
   localparam logic [7:0] OFS_FACTORS_S  = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;
   localparam logic [7:0] OFS_DISPLAY    = 8'h24;
   localparam logic [7:0] OFS_STATE      = 8'h28;

   // -------------------------------------------------------------------------
   // Reset values and legal ranges
   // -------------------------------------------------------------------------
   localparam logic [15:0] SEL_RESET       = 16'h0000;
   localparam logic [8:0]  BOOST_MIN       = 9'h064;  // 100 percent.
   localparam logic [8:0]  BOOST_MAX       = 9'h190;  // 400 percent.
   localparam logic [8:0]  BOOST_RESET     = 9'h064;
   localparam logic [11:0] DURATION_MAX    = 12'hbb8; // 30.00 s in 10 ms.
   localparam logic [11:0] DURATION_RESET  = 12'h000;

   // Fields that hold a factor in each selection word.
   localparam logic [15:0] PRI_USED_MASK   = 16'h3df7;
   localparam logic [15:0] SEC_USED_MASK   = 16'h3ff1;
   localparam int          SEC_THERMISTOR  = 11;

   // Control register fields.
   localparam int CTL_THERM_MODE = 0;
   localparam int CTL_VF_MODE    = 1;

   // Status register fields.
   localparam int ST_LIGHT  = 0;
   localparam int ST_TRIP   = 1;
   localparam int ST_ACCEL  = 2;
   localparam int ST_BITS   = 3;

   // Trip code reported when the thermistor trips at once.
   localparam logic [7:0] THERMISTOR_TRIP_CODE = 8'h04;
   localparam logic [7:0] LIGHT_ALARM_DISPLAY_CODE = 8'h01;
   localparam logic [7:0] NO_TRIP_CODE = 8'h00;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_MS       = 10;          // Duration unit is 10 ms.
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: hex_digit_if.sv
// Interface carrying one selection word to the hexadecimal digit converter.
`timescale 1ns/1ns
interface hex_digit_if;
   logic [15:0] word;     // Selection word to show.
   logic [27:0] digits;   // Four seven-segment patterns, leftmost highest.

   modport conv (input word, output digits);
   modport user (output word, input digits);
endinterface

// File: hex_digit_conv.sv
// Converts a 16-bit word into four seven-segment hexadecimal digit patterns.
`timescale 1ns/1ns
module hex_digit_conv (
   hex_digit_if.conv hx   // Word in, digit patterns out.
);

   // -------------------------------------------------------------------------
   // Nibble to segment pattern
   // -------------------------------------------------------------------------
   // Segments gfedcba; a to f use the lower-case shapes seen on the monitor.
   function automatic logic [6:0] seg(input logic [3:0] n);
      unique case (n)
         4'h0: seg = 7'h3f;
         4'h1: seg = 7'h06;
         4'h2: seg = 7'h5b;
         4'h3: seg = 7'h4f;
         4'h4: seg = 7'h66;
         4'h5: seg = 7'h6d;
         4'h6: seg = 7'h7d;
         4'h7: seg = 7'h07;
         4'h8: seg = 7'h7f;
         4'h9: seg = 7'h6f;
         4'ha: seg = 7'h5f;
         4'hb: seg = 7'h7c;
         4'hc: seg = 7'h58;
         4'hd: seg = 7'h5e;
         4'he: seg = 7'h7b;
         4'hf: seg = 7'h71;
      endcase
   endfunction

   // Digit 3 is the leftmost and shows bits 15 to 12.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : digit
         assign hx.digits[g*7 +: 7] = seg(hx.word[g*4 +: 4]);
      end
   endgenerate

endmodule

// File: light_alarm_preexcite.sv
// Light alarm selection, display, alarm output and pre-excitation sequencer.
//
// Functional notes
// - Each light alarm factor owns one bit, positions 0 to 15.
// - Primary word: overheat, external, braking, motor overloads, options, ports.
// - Secondary low byte: speed deviation, fan, prewarnings, service end.
// - Secondary high byte: setpoint loss, loop, torque, thermistor, run limits.
// - Four digits show the word, leftmost bits 15 to 12.
// - Each nibble shows as one hex digit, a to f above nine.
// - Thermistor mode one trips at once, never a light alarm.
// - Light alarm output turns on whenever a light alarm occurs.
// - Boost level accepts 100 to 400 percent only.
// - Duration accepts zero (disabled) or 1 to 3000 tens of ms.
// - Run with nonzero duration excites, then accelerates after the duration.
// - Pre-excite input starts excitation; run then ends it and accelerates.
// - Pre-excitation disabled under V/f control.
// - Each selection word accepts 0000 to ffff.
// - Selected factor is handled as light alarm, not trip.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module light_alarm_preexcite
   import light_alarm_pkg::*;
#(
   parameter int TICK = light_alarm_pkg::TICK_CYCLES  // Cycles per 10 ms.
) (
   input  wire logic        aclk,              // Clock, 10 MHz.
   input  wire logic        aresetn,           // Synchronous reset, low.
   input  wire logic [31:0] s_axi_awaddr,      // Write address.
   input  wire logic        s_axi_awvalid,     // Write address valid.
   output logic             s_axi_awready,     // Write address ready.
   input  wire logic [31:0] s_axi_wdata,       // Write data.
   input  wire logic [3:0]  s_axi_wstrb,       // Write byte strobes.
   input  wire logic        s_axi_wvalid,      // Write data valid.
   output logic             s_axi_wready,      // Write data ready.
   output logic [1:0]       s_axi_bresp,       // Write response.
   output logic             s_axi_bvalid,      // Write response valid.
   input  wire logic        s_axi_bready,      // Write response ready.
   input  wire logic [31:0] s_axi_araddr,      // Read address.
   input  wire logic        s_axi_arvalid,     // Read address valid.
   output logic             s_axi_arready,     // Read address ready.
   output logic [31:0]      s_axi_rdata,       // Read data.
   output logic [1:0]       s_axi_rresp,       // Read response.
   output logic             s_axi_rvalid,      // Read data valid.
   input  wire logic        s_axi_rready,      // Read data ready.
   input  wire logic [15:0] factors_pri,       // Primary factor events.
   input  wire logic [15:0] factors_sec,       // Secondary factor events.
   input  wire logic        run_cmd,           // Run command from sequence.
   input  wire logic        preexcite_input,   // Pre-excite pin, async.
   output logic             light_alarm_output, // Light alarm signal.
   output logic             trip,              // Drive must trip.
   output logic [7:0]       trip_code,         // Trip reason, 04 for the thermistor, else 00.
   output logic [7:0]       display_code,      // Alarm code on monitor.
   output logic             preexciting,       // Flux build-up in progress.
   output logic             accelerate,        // Acceleration allowed.
   output logic [27:0]      led_digits,        // Primary word segments.
   output logic             irq                // Interrupt, level.
);

   if (TICK < 1 || TICK > 24'hffffff) begin : g_bad_tick
      $error("TICK must be 1 to 16777215 cycles");
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef enum {PX_IDLE, PX_TIMED, PX_INPUT, PX_RUN} px_t;

   typedef struct packed {
      logic        aw_got, w_got, bvalid, rvalid;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic [31:0] rdata;
      logic [1:0]  bresp, rresp;
      logic [15:0] sel_pri, sel_sec;
      logic [8:0]  boost;
      logic [11:0] duration;
      logic [1:0]  ctl;
      logic [ST_BITS-1:0] status, mask;
      logic        light, trip;
      logic [7:0]  code, disp;
      px_t         px;
      logic [11:0] ticks;
      logic [23:0] div;
      logic [2:0]  pin_sync;
   } state_t;

   state_t q, d;
   hex_digit_if hx ();
   hex_digit_conv conv (.hx(hx));

   assign hx.word = q.sel_pri;

   // -------------------------------------------------------------------------
   // Combinational next state
   // -------------------------------------------------------------------------
   logic        wr_fire, rd_fire, pin_level, tick, therm_hit;
   logic [15:0] hit_pri, hit_sec, fault_pri, fault_sec;
   logic [15:0] wval;
   logic [ST_BITS-1:0] events;

   always_comb begin
      d = q;
      wval = q.wdata[15:0];
      // Handshake: a channel is taken once and held until the response.
      s_axi_awready = !q.aw_got && !q.bvalid;
      s_axi_wready  = !q.w_got && !q.bvalid;
      s_axi_arready = !q.rvalid;
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      wr_fire = q.aw_got && q.w_got;

      // Pin input passes three flops; a change counts when two and three agree.
      d.pin_sync = {q.pin_sync[1:0], preexcite_input};
      pin_level = (q.pin_sync[2] == q.pin_sync[1]) ? q.pin_sync[2] :
                  (q.px == PX_INPUT);

      hit_pri = factors_pri & PRI_USED_MASK;
      hit_sec = factors_sec & SEC_USED_MASK;
      therm_hit = q.ctl[CTL_THERM_MODE] && hit_sec[SEC_THERMISTOR];
      if (q.ctl[CTL_THERM_MODE]) hit_sec[SEC_THERMISTOR] = 1'b0;
      fault_pri = hit_pri & ~q.sel_pri;
      fault_sec = hit_sec & ~q.sel_sec;
      d.light = |(hit_pri & q.sel_pri) || |(hit_sec & q.sel_sec);
      d.trip  = therm_hit || |fault_pri || |fault_sec;
      d.code  = therm_hit ? THERMISTOR_TRIP_CODE : NO_TRIP_CODE;
      d.disp  = d.light ? LIGHT_ALARM_DISPLAY_CODE : NO_TRIP_CODE;

      // Divider for the 10 ms tick.
      tick = (q.div == 24'(TICK - 1));
      d.div = tick ? 24'h000000 : q.div + 24'h000001;

      unique case (q.px)
         PX_IDLE: begin
            d.ticks = 12'h000;
            if (run_cmd) begin
               if (q.duration != 12'h000 && !q.ctl[CTL_VF_MODE]) begin
                  d.px  = PX_TIMED;
                  d.div = 24'h000000;
               end else begin
                  d.px = PX_RUN;
               end
            end else if (pin_level && !q.ctl[CTL_VF_MODE]) begin
               d.px = PX_INPUT;
            end
         end
         PX_TIMED: begin
            if (!run_cmd) begin
               d.px = PX_IDLE;
            end else if (q.ctl[CTL_VF_MODE]) begin
               d.px = PX_RUN;
            end else if (tick) begin
               d.ticks = q.ticks + 12'h001;
               if (q.ticks + 12'h001 >= q.duration) begin
                  d.px = PX_RUN;
               end
            end
         end
         PX_INPUT: begin
            if (run_cmd) begin
               d.px = PX_RUN;
            end else if (!pin_level || q.ctl[CTL_VF_MODE]) begin
               d.px = PX_IDLE;
            end
         end
         PX_RUN: begin
            if (!run_cmd) begin
               d.px = PX_IDLE;
            end
         end
      endcase

      // Sticky events; a new event wins over a clear written in the same cycle.
      events = {d.px == PX_RUN && q.px != PX_RUN, d.trip && !q.trip,
                d.light && !q.light};

      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = RESP_OKAY;
         unique case (q.awaddr)
            OFS_SEL_PRI: begin
               if (q.wstrb[0]) d.sel_pri[7:0]  = wval[7:0];
               if (q.wstrb[1]) d.sel_pri[15:8] = wval[15:8];
            end
            OFS_SEL_SEC: begin
               if (q.wstrb[0]) d.sel_sec[7:0]  = wval[7:0];
               if (q.wstrb[1]) d.sel_sec[15:8] = wval[15:8];
            end
            OFS_BOOST: begin
               if (q.wdata[8:0] >= BOOST_MIN && q.wdata[8:0] <= BOOST_MAX
                   && q.wdata[31:9] == 23'h0) begin
                  d.boost = q.wdata[8:0];
               end else begin
                  d.bresp = RESP_SLVERR;
               end
            end
            OFS_DURATION: begin
               // zero or up to 30 s
               if (q.wdata[11:0] <= DURATION_MAX && q.wdata[31:12] == 20'h0)
                  d.duration = q.wdata[11:0];
               else
                  d.bresp = RESP_SLVERR;
            end
            OFS_CONTROL:  d.ctl  = q.wdata[1:0];
            OFS_STATUS:   d.status = q.status & ~q.wdata[ST_BITS-1:0];
            OFS_IRQ_MASK: d.mask = q.wdata[ST_BITS-1:0];
            default:      d.bresp = RESP_SLVERR;
         endcase
      end
      d.status = d.status | events;
      if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;

      rd_fire = s_axi_arvalid && s_axi_arready;
      if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         d.rdata  = 32'h00000000;
         unique case (s_axi_araddr[7:0])
            OFS_SEL_PRI:   d.rdata[15:0]  = q.sel_pri;
            OFS_SEL_SEC:   d.rdata[15:0]  = q.sel_sec;
            OFS_BOOST:     d.rdata[8:0]   = q.boost;
            OFS_DURATION:  d.rdata[11:0]  = q.duration;
            OFS_CONTROL:   d.rdata[1:0]   = q.ctl;
            OFS_FACTORS_P: d.rdata[15:0]  = hit_pri;
            OFS_FACTORS_S: d.rdata[15:0]  = hit_sec;
            OFS_STATUS:    d.rdata[ST_BITS-1:0] = q.status;
            OFS_IRQ_MASK:  d.rdata[ST_BITS-1:0] = q.mask;
            OFS_DISPLAY:   d.rdata[27:0]  = hx.digits;
            OFS_STATE:     d.rdata[11:0]  = q.ticks;
            default:       d.rresp = RESP_SLVERR;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q          <= '0;
         q.sel_pri  <= SEL_RESET;
         q.sel_sec  <= SEL_RESET;
         q.boost    <= BOOST_RESET;
         q.duration <= DURATION_RESET;
         q.px       <= PX_IDLE;
      end else begin
         q <= d;
      end
   end

   assign s_axi_bvalid       = q.bvalid;
   assign s_axi_bresp        = q.bresp;
   assign s_axi_rvalid       = q.rvalid;
   assign s_axi_rdata        = q.rdata;
   assign s_axi_rresp        = q.rresp;
   assign light_alarm_output = q.light;
   assign trip               = q.trip;
   assign trip_code          = q.code;
   assign display_code       = q.disp;
   assign preexciting        = (q.px == PX_TIMED) || (q.px == PX_INPUT);
   assign accelerate         = (q.px == PX_RUN);
   assign led_digits         = hx.digits;
   assign irq                = |(q.status & q.mask);

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   AST_THERM_NO_LIGHT: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(q.ctl[CTL_THERM_MODE]) && $past(factors_sec == 16'h0800)
      |-> !light_alarm_output && trip_code == THERMISTOR_TRIP_CODE)
      else $error("thermistor classed as light alarm");

   AST_LIGHT_ON: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(factors_pri & q.sel_pri & PRI_USED_MASK)) |=> light_alarm_output)
      else $error("light alarm output missed");

   AST_UNSEL_TRIPS: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(factors_pri & ~q.sel_pri & PRI_USED_MASK)) |=> trip)
      else $error("unselected factor did not trip");

   AST_SEL_NO_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
      (factors_sec == 16'h0 && (factors_pri & ~q.sel_pri) == 16'h0)
      |=> !trip)
      else $error("selected factor tripped");

   AST_BOOST_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      q.boost >= BOOST_MIN && q.boost <= BOOST_MAX)
      else $error("boost level out of range");

   AST_DUR_RANGE: assert property (@(posedge aclk) disable iff (!aresetn)
      q.duration <= DURATION_MAX)
      else $error("duration out of range");

   AST_VF_NO_PX: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[CTL_VF_MODE] ##1 q.ctl[CTL_VF_MODE] |-> !preexciting)
      else $error("excitation under V/f");

   AST_ZERO_DUR: assert property (@(posedge aclk) disable iff (!aresetn)
      q.px == PX_IDLE && run_cmd && q.duration == 12'h000
      |=> accelerate)
      else $error("zero duration did not accelerate");

   AST_INPUT_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
      q.px == PX_INPUT && run_cmd |=> accelerate && !preexciting)
      else $error("run did not end input excitation");

   AST_HEX_DIGIT: assert property (@(posedge aclk) disable iff (!aresetn)
      q.sel_pri[3:0] == 4'h1 |-> led_digits[6:0] == 7'h06)
      else $error("digit pattern wrong");

endmodule

// File: run_sequencer.sv
// Model of the outside run sequence driving the run and pre-excite lines.
`timescale 1ns/1ns
module run_sequencer #(
   parameter int FLUX = 12  // Cycles the sequence allows for flux.
) (
   input  wire logic aclk,            // Clock.
   input  wire logic go_pin,          // Start through the pre-excite pin.
   input  wire logic go_run,          // Start with a plain run command.
   input  wire logic stop,            // Drop both lines.
   output logic      run_cmd,         // Run command to the block.
   output logic      preexcite_input  // Pre-excite pin to the block.
);
   int cnt;

   // Both lines start low so the block never sees an unknown level.
   initial begin
      run_cmd = 1'b0;
      preexcite_input = 1'b0;
      cnt = 0;
   end

   // Pin mode times the flux delay here, since the block cannot know it.
   always @(posedge aclk) begin
      if (stop) begin
         run_cmd <= 1'b0;
         preexcite_input <= 1'b0;
         cnt <= 0;
      end else if (go_run) begin
         run_cmd <= 1'b1;
      end else if (go_pin || preexcite_input) begin
         preexcite_input <= 1'b1;
         if (cnt == FLUX) run_cmd <= 1'b1;
         else cnt <= cnt + 1;
      end
   end
endmodule

// File: light_alarm_mask_and_preexcite_tb.sv
// Self-checking testbench for the light alarm and pre-excitation block.
`timescale 1ns/1ns
module light_alarm_mask_and_preexcite_tb;
   import light_alarm_pkg::*;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb;
   logic [15:0] fpri, fsec;
   logic        run_cmd, pin, go_pin, go_run, stop, lao, trip, pre, acc, irq;
   logic [7:0]  tcode, dcode;
   logic [27:0] leds;
   int          err_count, num_checks;

   // Short tick keeps the pre-excitation run brief.
   light_alarm_preexcite #(.TICK(10)) u_light_alarm_preexcite (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .factors_pri(fpri), .factors_sec(fsec),
      .run_cmd(run_cmd), .preexcite_input(pin), .light_alarm_output(lao),
      .trip(trip), .trip_code(tcode), .display_code(dcode),
      .preexciting(pre), .accelerate(acc), .led_digits(leds), .irq(irq));

   run_sequencer #(.FLUX(12)) u_run_sequencer (
      .aclk(aclk), .go_pin(go_pin), .go_run(go_run), .stop(stop),
      .run_cmd(run_cmd), .preexcite_input(pin));

   // -----------------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------------
   task automatic wrap_up();
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic chk1(input logic got, exp, input string m);
      chk({31'h0, got}, {31'h0, exp}, m);
   endtask

   task automatic hang(input string m);
      err_count++;
      $display("wrong value at %0t: %s timed out", $time, m);
      wrap_up();
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // Address and data are offered together and dropped as each is taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      int n;
      logic [1:0] got;
      n = 0;
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         got = bresp;
      end while (bvalid !== 1'b1 && n < 40);
      if (n >= 40) hang("write");
      chk({30'h0, got}, {30'h0, r}, "write response");
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      int n;
      n = 0;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      if (n >= 40) hang("read");
      chk(rdata, e, "read data");
      chk({30'h0, rresp}, {30'h0, r}, "read response");
   endtask

   // Waits for acceleration (sel high) or for excitation (sel low).
   task automatic wt(input bit sel, input int lim);
      int n;
      n = 0;
      while ((sel ? acc : pre) !== 1'b1 && n < lim) begin
         @(posedge aclk);
         n++;
      end
      if (n >= lim) hang("sequencer");
   endtask

   task automatic halt();
      stop <= 1'b1;
      cyc(3);
      stop <= 1'b0;
   endtask

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   task automatic t_regs();
      chk({4'h0, leds}, {4'h0, {4{7'h3f}}}, "reset digits");
      rd(OFS_SEL_PRI, 32'h0, RESP_OKAY);
      rd(OFS_BOOST, 32'h64, RESP_OKAY);
      rd(OFS_DURATION, 32'h0, RESP_OKAY);
      rd(8'h3c, 32'h0, RESP_SLVERR);
      wr(OFS_BOOST, 32'h63, RESP_SLVERR);
      wr(OFS_BOOST, 32'h191, RESP_SLVERR);
      wr(OFS_BOOST, 32'h190, RESP_OKAY);
      rd(OFS_BOOST, 32'h190, RESP_OKAY);
      wr(OFS_DURATION, 32'hbb9, RESP_SLVERR);
      wr(OFS_DURATION, 32'hbb8, RESP_OKAY);
      rd(OFS_DURATION, 32'hbb8, RESP_OKAY);
      wr(OFS_SEL_SEC, 32'hffff, RESP_OKAY);
      rd(OFS_SEL_SEC, 32'hffff, RESP_OKAY);
      wr(OFS_SEL_PRI, 32'h3421, RESP_OKAY);
      cyc(2);
      chk({4'h0, leds}, {4'h0, 7'h4f, 7'h66, 7'h5b, 7'h06}, "digits");
   endtask

   // With nothing selected every used factor trips and unused ones do not.
   task automatic t_map();
      logic [31:0] used;
      used = {16'h3ff1, 16'h3df7};
      wr(OFS_SEL_PRI, 32'h0, RESP_OKAY);
      wr(OFS_SEL_SEC, 32'h0, RESP_OKAY);
      for (int i = 0; i < 32; i++) begin
         {fsec, fpri} <= 32'h1 << i;
         cyc(2);
         chk1(trip, used[i], "factor map");
      end
      {fsec, fpri} <= 32'h0;
      cyc(2);
   endtask

   task automatic t_alarm();
      wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
      wr(OFS_STATUS, 32'h7, RESP_OKAY);
      wr(OFS_SEL_PRI, 32'h1, RESP_OKAY);
      fpri <= 16'h0001;
      cyc(3);
      chk1(lao, 1'b1, "light output");
      chk1(trip, 1'b0, "selected trips");
      chk({24'h0, dcode}, 32'h1, "display code");
      chk1(irq, 1'b1, "irq raised");
      fpri <= 16'h0003;
      cyc(2);
      chk1(trip, 1'b1, "unselected trip");
      chk1(lao, 1'b1, "light kept");
      fpri <= 16'h0000;
      wr(OFS_STATUS, 32'h1, RESP_OKAY);
      cyc(2);
      chk1(irq, 1'b0, "irq masked or cleared");
      rd(OFS_STATUS, 32'h2, RESP_OKAY);
   endtask

   task automatic t_therm();
      wr(OFS_SEL_SEC, 32'h0800, RESP_OKAY);
      wr(OFS_CONTROL, 32'h1, RESP_OKAY);
      fsec <= 16'h0800;
      cyc(2);
      chk1(trip, 1'b1, "thermistor trip");
      chk({24'h0, tcode}, 32'h4, "thermistor code");
      chk1(lao, 1'b0, "no light in mode one");
      chk({24'h0, dcode}, 32'h0, "no display code");
      wr(OFS_CONTROL, 32'h0, RESP_OKAY);
      cyc(2);
      chk1(lao, 1'b1, "thermistor light");
      chk1(trip, 1'b0, "thermistor no trip");
      fsec <= 16'h0000;
   endtask

   task automatic t_timed();
      int n;
      wr(OFS_DURATION, 32'h2, RESP_OKAY);
      go_run <= 1'b1;
      @(posedge aclk);
      go_run <= 1'b0;
      cyc(3);
      chk1(pre, 1'b1, "excite started");
      chk1(acc, 1'b0, "early acceleration");
      n = 4;
      while (acc !== 1'b1 && n < 60) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 60) hang("acceleration");
      chk1(n >= 21 && n <= 26, 1'b1, "excite length");
      halt();
   endtask

   // V/f control and a zero duration both skip excitation.
   task automatic t_direct();
      for (int k = 0; k < 2; k++) begin
         wr(OFS_CONTROL, k ? 32'h0 : 32'h2, RESP_OKAY);
         wr(OFS_DURATION, k ? 32'h0 : 32'h2, RESP_OKAY);
         go_run <= 1'b1;
         @(posedge aclk);
         go_run <= 1'b0;
         cyc(4);
         chk1(acc, 1'b1, "direct start");
         chk1(pre, 1'b0, "no excite");
         halt();
      end
   endtask

   task automatic t_pin();
      go_pin <= 1'b1;
      @(posedge aclk);
      go_pin <= 1'b0;
      wt(1'b0, 10);
      chk1(acc, 1'b0, "pin holds acceleration");
      wt(1'b1, 30);
      chk1(pre, 1'b0, "run ends excite");
      halt();
   endtask

   // -----------------------------------------------------------------------
   // Clock and main sequence
   // -----------------------------------------------------------------------
   always #50 aclk = ~aclk;

   // Every input is defined at time zero; reset spans ten edges.
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      // Response ready lines stay high, so no call lowers and raises them.
      {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
      {awaddr, wdata, araddr} = 96'h0;
      wstrb = 4'hf;
      {fpri, fsec} = 32'h0;
      {go_pin, go_run} = 2'h0;
      stop = 1'b1;
      err_count = 0;
      num_checks = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      stop <= 1'b0;
      @(posedge aclk);
      t_regs();
      t_map();
      t_alarm();
      t_therm();
      t_timed();
      t_direct();
      t_pin();
      wrap_up();
   end
endmodule
